// ### bench/guard_timer_monitor.sv
`timescale 1ns/100ps

module guard_timer_monitor
  import guard_timer_pkg::*;
(
  // Clock and reset
  input wire logic       clk,
  input wire logic       rst,
  // Watched inputs
  input wire logic       chipResetIn,
  input wire logic       guardOscIn,
  input wire logic       alwaysOnFuse,
  input wire logic       kickInstruction,
  input wire logic [1:0] regAddr,
  input wire logic [7:0] regWdata,
  input wire logic       regWrite,
  input wire logic       regRead,
  // Watched outputs
  input wire logic [7:0] regRdata,
  input wire logic       guardResetPulse,
  input wire logic       irq
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  // Access qualifiers; calm excludes resets that would clear control
  wire logic calm = !chipResetIn && !guardResetPulse;
  wire logic wrC  = regWrite && regAddr == ADDR_CONTROL;
  wire logic rdC  = regRead && regAddr == ADDR_CONTROL && calm;
  wire logic rdF  = regRead && regAddr == ADDR_RESET_FLAG;
  wire logic wrF  = regWrite && regAddr == ADDR_RESET_FLAG;

  // Unlock write, then a quiet cycle
  sequence s_open;
    wrC && regWdata[4:3] == 2'b11 && calm ##1 !regWrite && calm;
  endsequence
  sequence s_cfg;
    wrC && !regWdata[UNLOCK_POS] && !alwaysOnFuse && calm ##1 !regWrite && calm;
  endsequence

  property p_unlock_held;
    s_open ##1 rdC |=> regRdata[UNLOCK_POS];
  endproperty
  a_unlock_held: assert property (p_unlock_held) else $error("unlock bit not visible");
  property p_unlock_drop;
    s_open ##1 !regWrite [*3] ##1 rdC |=> !regRdata[UNLOCK_POS];
  endproperty
  a_unlock_drop: assert property (p_unlock_drop) else $error("unlock bit stuck");
  property p_config;
    s_open ##1 s_cfg ##1 rdC |=> regRdata[3:0] == $past(regWdata[3:0], 3);
  endproperty
  a_config: assert property (p_config) else $error("config write not applied");
  property p_reserved;
    rdC |=> regRdata[7:5] == 3'h0;
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved bits set");
  property p_enable;
    wrC && regWdata[4:3] == 2'b01 && calm ##1 !regWrite && calm ##1 rdC |=> regRdata[ENABLE_POS];
  endproperty
  a_enable: assert property (p_enable) else $error("enable write lost");
  property p_fuse_on;
    alwaysOnFuse [*4] ##0 rdC |=> regRdata[ENABLE_POS];
  endproperty
  a_fuse_on: assert property (p_fuse_on) else $error("enable low with fuse on");
  property p_pulse_one;
    guardResetPulse |=> !guardResetPulse;
  endproperty
  a_pulse_one: assert property (p_pulse_one) else $error("reset pulse too long");
  property p_kick_wins;
    guardResetPulse |-> !$past(kickInstruction);
  endproperty
  a_kick_wins: assert property (p_kick_wins) else $error("timeout despite kick");
  property p_flag_set;
    guardResetPulse ##1 rdF |=> regRdata[FLAG_POS];
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("reset flag not set");
  property p_flag_clr;
    wrF && !regWdata[FLAG_POS] && calm ##1 calm ##1 rdF && calm |=> !regRdata[FLAG_POS];
  endproperty
  a_flag_clr: assert property (p_flag_clr) else $error("reset flag not cleared");
endmodule

bind guard_timer guard_timer_monitor u_mon (.clk, .rst, .chipResetIn, .guardOscIn, .alwaysOnFuse,
  .kickInstruction, .regAddr, .regWdata, .regWrite, .regRead, .regRdata, .guardResetPulse, .irq);

// ### bench/tb_guard_timer.sv
`timescale 1ns/100ps

module tb_guard_timer
  import guard_timer_pkg::*;
;
  localparam int TB = 4;
  logic        clk, rst, chipResetIn, guardOscIn, alwaysOnFuse, kickInstruction;
  logic        regWrite, regRead, guardResetPulse, irq, autoKick;
  logic [1:0]  regAddr;
  logic [7:0]  regWdata, regRdata;
  logic [2:0]  p, r;
  logic [31:0] seed;
  int          errCount, numChecks, cycles, oscCnt, n;

  guard_timer #(.TIMEOUT_BASE(TB)) DUT (.clk, .rst, .chipResetIn, .guardOscIn, .alwaysOnFuse,
    .kickInstruction, .regAddr, .regWdata, .regWrite, .regRead, .regRdata, .guardResetPulse, .irq);

  // 100 ns clock
  initial begin
    clk = 0;
    forever #50 clk = ~clk;
  end

  // Oscillator at a tenth of clk, optional kicks, hang guard
  always @(posedge clk) begin
    cycles <= cycles + 1;
    oscCnt <= (oscCnt == 4) ? 0 : oscCnt + 1;
    if (oscCnt == 4) guardOscIn <= ~guardOscIn;
    kickInstruction <= autoKick && cycles % 16 == 0;
    if (cycles == 20000) begin
      errCount++;
      results();
    end
  end

  function automatic logic [7:0] ctrl(input logic en, input logic [2:0] ps, input logic u = 1'b0);
    return {3'h0, u, en, ps};
  endfunction
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    numChecks++;
    if (got !== exp) begin
      errCount++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge clk);
    regWrite <= 1'b1;
    regAddr <= a;
    regWdata <= d;
    @(posedge clk);
    regWrite <= 1'b0;
  endtask
  task automatic rd(input logic [1:0] a, input logic [7:0] exp);
    @(posedge clk);
    regRead <= 1'b1;
    regAddr <= a;
    @(posedge clk);
    regRead <= 1'b0;
    #1;
    chk(regRdata, exp);
  endtask
  // Count cycles until the reset pulse, giving up at lim
  task automatic waitPulse(input int lim, output int cnt);
    cnt = 0;
    while (guardResetPulse !== 1'b1 && cnt < lim) begin
      @(posedge clk);
      #1;
      cnt++;
    end
  endtask
  task automatic results();
    if (errCount == 0 && numChecks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  // Main sequence
  initial begin
    {chipResetIn, guardOscIn, alwaysOnFuse, kickInstruction, regWrite, regRead} = '0;
    {regAddr, regWdata, errCount, numChecks, cycles, oscCnt} = '0;
    rst = 1'b1;
    autoKick = 1'b1;
    seed = 32'ha20c464c;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    repeat (3) @(posedge clk);
    rd(ADDR_CONTROL, 8'h00);
    rd(ADDR_RESET_FLAG, 8'h00);
    wr(ADDR_CONTROL, 8'h0f);
    rd(ADDR_CONTROL, ctrl(1, 0));
    wr(ADDR_CONTROL, 8'h00);
    rd(ADDR_CONTROL, ctrl(1, 0));
    rd(ADDR_EVENTS, 8'h02);
    rd(ADDR_EVENTS, 8'h00);
    r = rnd();
    for (int i = 0; i < 8; i++) begin
      p = 3'(i) ^ r;
      wr(ADDR_CONTROL, 8'h18);
      wr(ADDR_CONTROL, ctrl(1, p));
      rd(ADDR_CONTROL, ctrl(1, p));
    end
    wr(ADDR_CONTROL, 8'h18);
    rd(ADDR_CONTROL, ctrl(1, p, 1));
    repeat (3) @(posedge clk);
    rd(ADDR_CONTROL, ctrl(1, p));
    wr(ADDR_CONTROL, 8'h18);
    repeat (5) @(posedge clk);
    wr(ADDR_CONTROL, 8'h00);
    rd(ADDR_CONTROL, ctrl(1, p));
    wr(ADDR_CONTROL, 8'h18);
    wr(ADDR_CONTROL, 8'h00);
    rd(ADDR_CONTROL, 8'h00);
    wr(ADDR_EVENT_MASK, 8'(rnd()));
    wr(ADDR_EVENT_MASK, 8'h01);
    rd(ADDR_EVENT_MASK, 8'h01);
    rd(ADDR_EVENTS, 8'h06);
    autoKick = 1'b0;
    for (int s = 0; s < 2; s++) begin
      wr(ADDR_CONTROL, 8'h18);
      wr(ADDR_CONTROL, ctrl(1, 3'(s)));
      waitPulse(3000, n);
      chk(8'(n >= 10 * (TB << s) - 12 && n <= 10 * (TB << s) + 8), 8'h01);
      rd(ADDR_RESET_FLAG, 8'h08);
      chk({7'h0, irq}, 8'h01);
      rd(ADDR_EVENTS, 8'h05);
      @(posedge clk);
      #1;
      chk({7'h0, irq}, 8'h00);
      rd(ADDR_CONTROL, 8'h00);
      wr(ADDR_RESET_FLAG, 8'h00);
      rd(ADDR_RESET_FLAG, 8'h00);
    end
    autoKick = 1'b1;
    wr(ADDR_CONTROL, 8'h18);
    wr(ADDR_CONTROL, ctrl(1, 0));
    waitPulse(250, n);
    chk(8'(n), 8'hfa);
    @(posedge clk);
    chipResetIn <= 1'b1;
    @(posedge clk);
    chipResetIn <= 1'b0;
    rd(ADDR_CONTROL, 8'h00);
    @(posedge clk);
    alwaysOnFuse <= 1'b1;
    repeat (4) @(posedge clk);
    rd(ADDR_CONTROL, ctrl(1, 0));
    wr(ADDR_CONTROL, 8'h18);
    wr(ADDR_CONTROL, 8'h05);
    rd(ADDR_CONTROL, ctrl(1, 5));
    wr(ADDR_CONTROL, 8'h00);
    rd(ADDR_CONTROL, ctrl(1, 5));
    results();
  end
endmodule

// ### hw/guard_timer.sv
// Chosen here: the strobed register port and the placing of the registers.
`timescale 1ns/100ps

// Function
// - Counter advances on rising edges of the separate watchdog oscillator, nominally 1 MHz.
// - The kick instruction clears the counter and starts a fresh period.
// - Counter also clears when the watchdog is disabled and on any chip reset.
// - Period elapsing without a kick issues a chip reset.
// - Period select bits 2..0 give 16,384 oscillator cycles times two to its value.
// - Control bits 7..5 are reserved and read as zero.
// - Change unlock bit 4 clears itself four system clock cycles after being set.
// - Enable bit 3: one enables, zero disables only while unlock bit is one.
// - Fuse unprogrammed: starts disabled, enable may be set anytime without sequence.
// - Fuse unprogrammed: period change or disable needs unlock write, then config write.
// - Fuse programmed: watchdog always enabled and enable bit reads one.
// - Fuse programmed: period change needs the sequence; written enable value is ignored.
// - Timeout produces an internal reset pulse one system clock long.
// - Watchdog reset sets the reset flag; power-on reset or writing zero clears it.
module guard_timer
  import guard_timer_pkg::*;
#(
  parameter int TIMEOUT_BASE = TIMEOUT_BASE_OSC
) (
  // System clock and power-on reset
  input  wire logic       clk,
  input  wire logic       rst,
  // Other chip reset sources, synchronous to clk
  input  wire logic       chipResetIn,
  // Watchdog oscillator and always-on fuse, asynchronous pins
  input  wire logic       guardOscIn,
  input  wire logic       alwaysOnFuse,
  // Kick instruction strobe from the core
  input  wire logic       kickInstruction,
  // Register port
  input  wire logic [1:0] regAddr,
  input  wire logic [7:0] regWdata,
  input  wire logic       regWrite,
  input  wire logic       regRead,
  output logic      [7:0] regRdata,
  // Watchdog reset pulse and event interrupt
  output logic            guardResetPulse,
  output logic            irq
);

  typedef struct packed {
    logic                   enable;
    logic                   unlock;
    logic [2:0]             unlockCnt;
    logic [2:0]             period;
    logic [COUNT_WIDTH-1:0] count;
    logic                   oscPrev;
    logic                   resetPulse;
    logic                   resetFlag;
    logic [EV_WIDTH-1:0]    events;
    logic [EV_WIDTH-1:0]    mask;
    logic [7:0]             rdata;
    logic                   irq;
  } guard_state_t;

  guard_state_t state_reg;
  guard_state_t state_next;

  logic [1:0]  syncLevels;
  logic        oscSync;
  logic        fuseSync;
  logic        oscTick;
  logic        enableEff;
  logic [31:0] periodLimit;
  logic        timeout;
  logic        ctrlWrite;
  logic        wrUnlock;
  logic        wrEnable;
  logic [2:0]  wrPeriod;
  logic        startSeq;
  logic [7:0]  controlView;
  logic [EV_WIDTH-1:0] eventSet;
  logic [EV_WIDTH-1:0] eventsNext;
  logic        wrMask;
  logic        wrFlag;
  logic        clrFlag;
  logic        rdEvents;
  logic        ctrlReset;
  logic        applyCfg;
  logic        ignoredDisable;
  logic [7:0]  eventsView;
  logic [7:0]  maskView;
  logic [7:0]  flagView;

  // Oscillator and fuse come from outside the clk domain
  pin_sync u_pin_sync (
    .clk     (clk),
    .rst     (rst),
    .asyncIn ({alwaysOnFuse, guardOscIn}),
    .syncOut (syncLevels)
  );

  assign oscSync  = syncLevels[0];
  assign fuseSync = syncLevels[1];

  // One tick per rising oscillator edge, seen after synchronisation
  assign oscTick = oscSync & ~state_reg.oscPrev;

  // Fuse forces the watchdog on regardless of the stored bit
  assign enableEff = state_reg.enable | fuseSync;

  // Timeout length in oscillator cycles, doubled per select step
  assign periodLimit = 32'(TIMEOUT_BASE) << state_reg.period;

  // Last count of the period reached on an oscillator tick
  // A kick in the same cycle wins over expiry, so no stale pulse escapes
  assign timeout = enableEff & oscTick & ~kickInstruction
                 & ({11'h000, state_reg.count} == periodLimit - 32'h1);

  // Decoded control write fields
  assign ctrlWrite = regWrite & (regAddr == ADDR_CONTROL);
  assign wrUnlock  = regWdata[UNLOCK_POS];
  assign wrEnable  = regWdata[ENABLE_POS];
  assign wrPeriod  = regWdata[PERIOD_MSB:PERIOD_LSB];

  // Unlock opens only when unlock and enable are written together
  assign startSeq = ctrlWrite & wrUnlock & wrEnable;

  // Control read view, reserved bits zero
  always_comb begin
    controlView                           = 8'h00;
    controlView[UNLOCK_POS]               = state_reg.unlock;
    controlView[ENABLE_POS]               = enableEff;
    controlView[PERIOD_MSB:PERIOD_LSB]    = state_reg.period;
  end

  // Hardware events that feed the sticky status
  always_comb begin
    eventSet                 = '0;
    eventSet[EV_TIMEOUT_POS] = timeout;
    eventSet[EV_BLOCKED_POS] = ctrlWrite & ~wrEnable & ~wrUnlock
                             & enableEff & ~state_reg.unlock;
    eventSet[EV_CHANGED_POS] = ctrlWrite & ~wrUnlock & state_reg.unlock;
  end

  // Mask register write
  assign wrMask = regWrite & (regAddr == ADDR_EVENT_MASK);

  // Reset flag register write
  assign wrFlag = regWrite & (regAddr == ADDR_RESET_FLAG);

  // Only a written zero clears the flag; a one has no effect
  assign clrFlag = wrFlag & ~regWdata[FLAG_POS];

  // Reading the events register clears them
  assign rdEvents = regRead & (regAddr == ADDR_EVENTS);

  // Any chip reset, our own included, restores control state
  assign ctrlReset = chipResetIn | state_reg.resetPulse;

  // Second step of the timed sequence, inside the window
  assign applyCfg = ctrlWrite & ~startSeq & state_reg.unlock & ~wrUnlock;

  // Disable attempt outside the window; kept for visibility only
  assign ignoredDisable = ctrlWrite & ~wrEnable & ~wrUnlock & ~state_reg.unlock;

  // Sticky event bits; a new event beats the clearing read
  for (genvar i = 0; i < EV_WIDTH; i++) begin : g_event
    assign eventsNext[i] = eventSet[i] | (state_reg.events[i] & ~rdEvents);
  end

  // Status views, unused bits read as zero
  always_comb begin
    eventsView               = 8'h00;
    eventsView[EV_WIDTH-1:0] = state_reg.events;
    maskView                 = 8'h00;
    maskView[EV_WIDTH-1:0]   = state_reg.mask;
    flagView                 = 8'h00;
    flagView[FLAG_POS]       = state_reg.resetFlag;
  end


  // Next-state logic
  always_comb begin
    state_next            = state_reg;
    state_next.oscPrev    = oscSync;
    state_next.resetPulse = 1'b0;

    // Oscillator counter, cleared by kick, disable or timeout
    if (kickInstruction) begin
      state_next.count = '0;
    end else if (!enableEff) begin
      state_next.count = '0;
    end else if (timeout) begin
      state_next.count = '0;
    end else if (oscTick) begin
      state_next.count = state_reg.count + 1'b1;
    end


    // A single-cycle pulse to the reset logic on expiry
    if (timeout) begin
      state_next.resetPulse = 1'b1;
    end


    // Unlock window counts down system clocks, then self-clears
    if (state_reg.unlock) begin
      if (state_reg.unlockCnt <= 3'h1) begin
        state_next.unlock    = 1'b0;
        state_next.unlockCnt = 3'h0;
      end else begin
        state_next.unlockCnt = state_reg.unlockCnt - 3'h1;
      end
    end


    // Control register writes
    if (ctrlWrite) begin
      if (startSeq) begin
        // First step: open or reopen the window and set enable
        state_next.unlock    = 1'b1;
        state_next.unlockCnt = UNLOCK_CYCLES;
        state_next.enable    = 1'b1;
      end else if (applyCfg) begin
        // Second step within the window: apply period and enable
        state_next.period    = wrPeriod;
        state_next.enable    = fuseSync ? 1'b1 : wrEnable;
        state_next.unlock    = 1'b0;
        state_next.unlockCnt = 3'h0;
        if (!wrEnable && !fuseSync) begin
          state_next.count = '0;
        end
      end else if (wrEnable) begin
        // Outside the window enabling is always allowed
        state_next.enable = 1'b1;
      end
      // A zero enable outside the window is ignored
    end


    // Reset flag: set with the pulse so a read right after sees it
    if (clrFlag) begin
      state_next.resetFlag = 1'b0;
    end
    if (timeout) begin
      state_next.resetFlag = 1'b1;
    end

    // Mask register write
    if (wrMask) begin
      state_next.mask = regWdata[EV_WIDTH-1:0];
    end


    // Read data stand one cycle after the read strobe
    state_next.rdata = 8'h00;
    if (regRead) begin
      case (regAddr)
        ADDR_CONTROL:    state_next.rdata = controlView;
        ADDR_EVENTS:     state_next.rdata = eventsView;
        ADDR_EVENT_MASK: state_next.rdata = maskView;
        ADDR_RESET_FLAG: state_next.rdata = flagView;
        default:         state_next.rdata = 8'h00;
      endcase
    end


    // Sticky events cleared by a read; a new event in that cycle wins
    state_next.events = eventsNext;

    // Other chip resets and our own reset pulse restore control state
    if (ctrlReset) begin
      state_next.enable    = 1'b0;
      state_next.unlock    = 1'b0;
      state_next.unlockCnt = 3'h0;
      state_next.period    = PERIOD_RESET;
      state_next.count     = '0;
    end

    // Level interrupt from unmasked sticky events
    state_next.irq = |(state_next.events & state_next.mask);
  end

  // Register the whole state; power-on reset clears every field
  always_ff @(posedge clk) begin
    if (rst) begin
      state_reg        <= '0;
      state_reg.period <= PERIOD_RESET;
      state_reg.mask   <= MASK_RESET;
    end else begin
      state_reg <= state_next;
    end
  end

  // Outputs straight from flip-flops
  assign regRdata        = state_reg.rdata;
  assign guardResetPulse = state_reg.resetPulse;
  assign irq             = state_reg.irq;

endmodule

// ### hw/pin_sync.sv
`timescale 1ns/100ps

// Two-flop synchroniser for asynchronous pin levels
module pin_sync (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  // Asynchronous levels in, synchronised levels out
  input  wire logic [1:0] asyncIn,
  output logic      [1:0] syncOut
);

  typedef struct packed {
    logic [1:0] stage1;
    logic [1:0] stage2;
  } sync_state_t;

  sync_state_t state_reg;
  sync_state_t state_next;

  // First stage feeds only the second stage
  always_comb begin
    state_next        = state_reg;
    state_next.stage1 = asyncIn;
    state_next.stage2 = state_reg.stage1;
  end

  // Registered copy
  always_ff @(posedge clk) begin
    if (rst) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign syncOut = state_reg.stage2;

endmodule

// ### inc/guard_timer_pkg.sv
package guard_timer_pkg;

  // Register map on the plain register port, word index per register
  localparam logic [1:0] ADDR_CONTROL    = 2'h0;
  localparam logic [1:0] ADDR_EVENTS     = 2'h1;
  localparam logic [1:0] ADDR_EVENT_MASK = 2'h2;
  localparam logic [1:0] ADDR_RESET_FLAG = 2'h3;

  // Control register field positions
  localparam int UNLOCK_POS    = 4;
  localparam int ENABLE_POS    = 3;
  localparam int PERIOD_MSB    = 2;
  localparam int PERIOD_LSB    = 0;
  localparam int RESERVED_MSB  = 7;
  localparam int RESERVED_LSB  = 5;

  // Event register field positions (events and mask share the layout)
  localparam int EV_TIMEOUT_POS  = 0;
  localparam int EV_BLOCKED_POS  = 1;
  localparam int EV_CHANGED_POS  = 2;
  localparam int EV_WIDTH        = 3;

  // Reset flag register field position
  localparam int FLAG_POS = 3;

  // Reset values
  localparam logic [2:0] PERIOD_RESET = 3'h0;
  localparam logic [2:0] MASK_RESET   = 3'h0;

  // Watchdog oscillator, nominal rate and base period
  localparam int OSC_FREQ_HZ       = 1000000;
  localparam int TIMEOUT_BASE_OSC  = 16384;
  localparam int COUNT_WIDTH       = 21;

  // System clock and the unlock window
  localparam int CLK_FREQ_HZ       = 10000000;
  localparam int UNLOCK_CYCLES_NUM = 4;
  localparam logic [2:0] UNLOCK_CYCLES = 3'(UNLOCK_CYCLES_NUM);

  // Oscillator must be slow enough for two-flop sampling to see every edge
  localparam int OSC_SAMPLE_RATIO  = CLK_FREQ_HZ / OSC_FREQ_HZ;

endpackage
